// ===== logic/csm_pkg.sv
// Purpose: Shared constants for the clock source and monitor control block
// Assumes: 8-bit register port, one clock at 250 MHz
// Notes: Offsets are register indices on the plain register port
package csm_pkg;

   // Register offsets
   localparam logic [2:0] OFF_CTRL = 3'h0;
   localparam logic [2:0] OFF_IRQ_STAT = 3'h1;
   localparam logic [2:0] OFF_IRQ_MASK = 3'h2;
   localparam logic [2:0] OFF_CFG = 3'h3;
   localparam logic [2:0] OFF_DCO_STAGE = 3'h4;
   localparam logic [2:0] OFF_DCO_DIV = 3'h5;

   // Control register field positions
   localparam int BIT_EXT_STABLE = 0;
   localparam int BIT_EXT_ON = 1;
   localparam int BIT_INT_STABLE = 2;
   localparam int BIT_INT_ON = 3;
   localparam int BIT_CLK_SEL = 4;
   localparam int BIT_MON_ON = 5;
   localparam int BIT_MON_FLAG = 6;
   localparam int BIT_MON_IRQ_EN = 7;

   // Interrupt status and mask field positions
   localparam int BIT_EV_FAIL = 0;
   localparam int BIT_EV_SWITCH = 1;
   localparam int NUM_EV = 2;

   // Configuration register field positions
   localparam int BIT_EXT_SLOW = 0;

   // Reset values
   localparam logic RST_INT_ON = 1'b1;
   localparam logic RST_EXT_ON = 1'b0;
   localparam logic RST_CLK_SEL = 1'b0;
   localparam logic RST_EXT_SLOW = 1'b0;
   localparam logic [7:0] RST_DCO_STAGE = 8'h80;
   localparam logic [3:0] RST_DCO_DIV = 4'h0;
   localparam logic [1:0] RST_IRQ_MASK = 2'h0;

   // Divider control saturates here
   localparam logic [3:0] DCO_DIV_MAX = 4'h9;
   localparam logic [7:0] DCO_STAGE_TOP = 8'hff;

   // Loop filter states
   typedef enum logic [2:0] {
      LF_IDLE = 3'b001,
      LF_UP = 3'b010,
      LF_DOWN = 3'b100
   } csm_lf_state_t;

endpackage

// ===== logic/csm_sync3.sv
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Input is asynchronous to core_clk
// Notes: Output follows once stages two and three agree
`timescale 1ns/1ns
module csm_sync3 (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic async_in,
   output logic sync_out
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic out_q;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         out_q <= 1'b0;
      end else begin
         s1_q <= async_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            out_q <= s3_q;
         end
      end
   end

   assign sync_out = out_q;
endmodule

// ===== logic/csm_ctrl.sv
// Purpose: Clock source enable, switch and clock monitor control
// Assumes: Analog stable and inactivity indications arrive asynchronously
// Notes: Clock muxes themselves are glitch-free cells outside this block
//
// Summary of operation
// - Source select needs target on and stable
// - Internal clock stays on while selected; a write that selects it with its on bit clear turns it off
// - External select waits for on and stable; a select written before then is dropped, not held
// - Monitor enable needs both clocks on, stable
// - Monitor interrupt enable needs monitor on
// - Monitor flag readable at bit six
// - Flag cleared by read-set then write-zero
// - Monitor stays on after stability loss
// - Failure forces selection of surviving clock
// - Oscillator period moves in discrete steps
// - Select high routes external, low internal
// - Internal clock selected during reset
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/1ns
module csm_ctrl (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic int_stable_raw,
   input wire logic ext_stable_raw,
   input wire logic int_off_raw,
   input wire logic ext_off_raw,
   input wire logic lf_inc,
   input wire logic lf_dec,
   output logic int_clock_en,
   output logic ext_clock_en,
   output logic osc_sel_ext,
   output logic tb_sel_ext,
   output logic monitor_en,
   output logic ext_slow_cfg,
   output logic [3:0] dco_divider_ctl,
   output logic [7:0] dco_stage_ctl,
   output logic monitor_irq,
   output logic irq
);

   // Saturating step of the coded oscillator setting
   function automatic logic [11:0] dco_step(
      input logic [3:0] div,
      input logic [7:0] stg,
      input logic up
   );
      logic [11:0] res;
      res = {div, stg};
      if (up) begin
         if (stg != csm_pkg::DCO_STAGE_TOP) begin
            res = {div, stg + 8'h01};
         end else if (div < csm_pkg::DCO_DIV_MAX) begin
            res = {div + 4'h1, 8'h00};
         end
      end else begin
         if (stg != 8'h00) begin
            res = {div, stg - 8'h01};
         end else if (div != 4'h0) begin
            res = {div - 4'h1, csm_pkg::DCO_STAGE_TOP};
         end
      end
      return res;
   endfunction

   logic int_stable_s;
   logic ext_stable_s;
   logic int_off_s;
   logic ext_off_s;

   csm_sync3 u_sync_int_stable (
      .core_clk(core_clk),
      .reset(reset),
      .async_in(int_stable_raw),
      .sync_out(int_stable_s)
   );
   csm_sync3 u_sync_ext_stable (
      .core_clk(core_clk),
      .reset(reset),
      .async_in(ext_stable_raw),
      .sync_out(ext_stable_s)
   );
   csm_sync3 u_sync_int_off (
      .core_clk(core_clk),
      .reset(reset),
      .async_in(int_off_raw),
      .sync_out(int_off_s)
   );
   csm_sync3 u_sync_ext_off (
      .core_clk(core_clk),
      .reset(reset),
      .async_in(ext_off_raw),
      .sync_out(ext_off_s)
   );

   logic int_on_q;
   logic int_on_d;
   logic ext_on_q;
   logic ext_on_d;
   logic clk_sel_q;
   logic clk_sel_d;
   logic mon_on_q;
   logic mon_on_d;
   logic mon_flag_q;
   logic mon_flag_d;
   logic mon_ie_q;
   logic mon_ie_d;
   logic flag_seen_q;
   logic flag_seen_d;
   logic tb_sel_q;
   logic fail_prev_q;
   logic ext_slow_q;
   logic [csm_pkg::NUM_EV-1:0] ev_stat_q;
   logic [csm_pkg::NUM_EV-1:0] ev_stat_d;
   logic [csm_pkg::NUM_EV-1:0] ev_mask_q;
   logic [3:0] dco_div_q;
   logic [7:0] dco_stg_q;
   logic [11:0] dco_next;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   csm_pkg::csm_lf_state_t lf_state_q;
   csm_pkg::csm_lf_state_t lf_state_d;

   // Address decode
   wire sel_ctrl = reg_addr == csm_pkg::OFF_CTRL;
   wire wr_ctrl = reg_wr && sel_ctrl;
   wire rd_ctrl = reg_rd && sel_ctrl;
   wire wr_stat = reg_wr && (reg_addr == csm_pkg::OFF_IRQ_STAT);
   wire wr_mask = reg_wr && (reg_addr == csm_pkg::OFF_IRQ_MASK);
   wire wr_cfg = reg_wr && (reg_addr == csm_pkg::OFF_CFG);

   // Stable indications are dropped while the source is off or idle
   wire int_stable = int_stable_s && int_on_q && !int_off_s;
   wire ext_stable = ext_stable_s && ext_on_q && !ext_off_s;

   // Inactivity only raises a failure through the monitor
   wire int_fail = mon_on_q && int_off_s && !ext_off_s;
   wire ext_fail = mon_on_q && ext_off_s && !int_off_s;
   wire any_fail = int_fail || ext_fail;
   wire fail_rise = any_fail && !fail_prev_q;

   wire [7:0] ctrl_view = {mon_ie_q, mon_flag_q, mon_on_q, clk_sel_q,
                           int_on_q, int_stable, ext_on_q, ext_stable};

   wire w_sel = reg_wdata[csm_pkg::BIT_CLK_SEL];
   wire w_int_on = reg_wdata[csm_pkg::BIT_INT_ON];
   wire w_ext_on = reg_wdata[csm_pkg::BIT_EXT_ON];
   wire w_mon_on = reg_wdata[csm_pkg::BIT_MON_ON];
   wire w_mon_ie = reg_wdata[csm_pkg::BIT_MON_IRQ_EN];
   wire w_flag = reg_wdata[csm_pkg::BIT_MON_FLAG];

   wire sel_ok = w_sel ? (ext_on_q && ext_stable) : (int_on_q && int_stable);
   wire sel_change = wr_ctrl && (w_sel != clk_sel_q) && sel_ok;

   always_comb begin
      clk_sel_d = clk_sel_q;
      if (sel_change) begin
         clk_sel_d = w_sel;
      end
      if (int_fail) begin
         clk_sel_d = 1'b1;
      end else if (ext_fail) begin
         clk_sel_d = 1'b0;
      end
   end

   always_comb begin
      int_on_d = int_on_q;
      ext_on_d = ext_on_q;
      if (wr_ctrl) begin
         int_on_d = w_int_on || !clk_sel_q;
         // Same guard for the external side keeps it on while the registered select is external
         ext_on_d = w_ext_on || clk_sel_q;
      end
   end

   always_comb begin
      mon_on_d = mon_on_q;
      mon_ie_d = mon_ie_q;
      if (wr_ctrl) begin
         if (w_mon_on && !mon_on_q) begin
            mon_on_d = int_on_q && int_stable && ext_on_q && ext_stable;
         end else if (!w_mon_on) begin
            mon_on_d = 1'b0;
         end
         if (w_mon_ie) begin
            mon_ie_d = mon_on_q || mon_ie_q;
         end else begin
            mon_ie_d = 1'b0;
         end
      end
   end

   always_comb begin
      flag_seen_d = flag_seen_q;
      mon_flag_d = mon_flag_q;
      // read finding it set arms the clear
      if (rd_ctrl && mon_flag_q) begin
         flag_seen_d = 1'b1;
      end
      if (wr_ctrl && !w_flag && flag_seen_q) begin
         mon_flag_d = 1'b0;
         flag_seen_d = 1'b0;
      end
      // A failure in the clearing cycle wins
      if (fail_rise) begin
         mon_flag_d = 1'b1;
         flag_seen_d = 1'b0;
      end
   end

   always_comb begin
      ev_stat_d = ev_stat_q;
      if (wr_stat) begin
         ev_stat_d = ev_stat_q & ~reg_wdata[csm_pkg::NUM_EV-1:0];
      end
      if (fail_rise) begin
         ev_stat_d[csm_pkg::BIT_EV_FAIL] = 1'b1;
      end
      if (clk_sel_d != clk_sel_q) begin
         ev_stat_d[csm_pkg::BIT_EV_SWITCH] = 1'b1;
      end
   end

   always_comb begin
      lf_state_d = csm_pkg::LF_IDLE;
      dco_next = {dco_div_q, dco_stg_q};
      case (lf_state_q)
         csm_pkg::LF_IDLE: begin
            if (lf_inc && !lf_dec) begin
               lf_state_d = csm_pkg::LF_UP;
            end else if (lf_dec && !lf_inc) begin
               lf_state_d = csm_pkg::LF_DOWN;
            end
         end
         csm_pkg::LF_UP: begin
            dco_next = dco_step(dco_div_q, dco_stg_q, 1'b1);
         end
         csm_pkg::LF_DOWN: begin
            dco_next = dco_step(dco_div_q, dco_stg_q, 1'b0);
         end
         default: begin
            lf_state_d = csm_pkg::LF_IDLE;
         end
      endcase
   end

   always_comb begin
      case (reg_addr)
         csm_pkg::OFF_CTRL: begin
            rdata_d = ctrl_view;
         end
         csm_pkg::OFF_IRQ_STAT: begin
            rdata_d = {6'h00, ev_stat_q};
         end
         csm_pkg::OFF_IRQ_MASK: begin
            rdata_d = {6'h00, ev_mask_q};
         end
         csm_pkg::OFF_CFG: begin
            rdata_d = {7'h00, ext_slow_q};
         end
         csm_pkg::OFF_DCO_STAGE: begin
            rdata_d = dco_stg_q;
         end
         csm_pkg::OFF_DCO_DIV: begin
            rdata_d = {4'h0, dco_div_q};
         end
         default: begin
            rdata_d = 8'h00;
         end
      endcase
      if (!reg_rd) begin
         rdata_d = 8'h00;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         int_on_q <= csm_pkg::RST_INT_ON;
         ext_on_q <= csm_pkg::RST_EXT_ON;
         clk_sel_q <= csm_pkg::RST_CLK_SEL;
         mon_on_q <= 1'b0;
         mon_flag_q <= 1'b0;
         mon_ie_q <= 1'b0;
         flag_seen_q <= 1'b0;
      end else begin
         int_on_q <= int_on_d;
         ext_on_q <= ext_on_d;
         clk_sel_q <= clk_sel_d;
         mon_on_q <= mon_on_d;
         mon_flag_q <= mon_flag_d;
         mon_ie_q <= mon_ie_d;
         flag_seen_q <= flag_seen_d;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         ev_stat_q <= '0;
         ev_mask_q <= csm_pkg::RST_IRQ_MASK;
         ext_slow_q <= csm_pkg::RST_EXT_SLOW;
         fail_prev_q <= 1'b0;
         rdata_q <= 8'h00;
      end else begin
         ev_stat_q <= ev_stat_d;
         if (wr_mask) begin
            ev_mask_q <= reg_wdata[csm_pkg::NUM_EV-1:0];
         end
         if (wr_cfg) begin
            ext_slow_q <= reg_wdata[csm_pkg::BIT_EXT_SLOW];
         end
         fail_prev_q <= any_fail;
         rdata_q <= rdata_d;
      end
   end

   // Timebase follows the external enable unless a failure overrides it
   always_ff @(posedge core_clk) begin
      if (reset) begin
         tb_sel_q <= 1'b0;
      end else if (int_fail) begin
         tb_sel_q <= 1'b1;
      end else if (ext_fail) begin
         tb_sel_q <= 1'b0;
      end else begin
         tb_sel_q <= ext_on_d;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         lf_state_q <= csm_pkg::LF_IDLE;
         dco_stg_q <= csm_pkg::RST_DCO_STAGE;
         dco_div_q <= csm_pkg::RST_DCO_DIV;
      end else begin
         lf_state_q <= lf_state_d;
         dco_div_q <= dco_next[11:8];
         dco_stg_q <= dco_next[7:0];
      end
   end

   assign osc_sel_ext = clk_sel_q;
   assign tb_sel_ext = tb_sel_q;
   assign int_clock_en = int_on_q;
   assign ext_clock_en = ext_on_q;
   assign monitor_en = mon_on_q;
   assign ext_slow_cfg = ext_slow_q;
   assign dco_divider_ctl = dco_div_q;
   assign dco_stage_ctl = dco_stg_q;
   assign reg_rdata = rdata_q;
   assign monitor_irq = mon_flag_q && mon_ie_q;
   assign irq = |(ev_stat_q & ev_mask_q);

endmodule

// ===== verification/csm_ctrl_chk.sv
// Purpose: Port checker for the clock source and monitor control block
// Assumes: Sees only the ports of csm_ctrl
// Notes: Raw inputs need four edges to be seen, failures get seven
`timescale 1ns/1ns
module csm_ctrl_chk (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic int_stable_raw,
   input wire logic ext_stable_raw,
   input wire logic int_off_raw,
   input wire logic ext_off_raw,
   input wire logic lf_inc,
   input wire logic lf_dec,
   input wire logic int_clock_en,
   input wire logic ext_clock_en,
   input wire logic osc_sel_ext,
   input wire logic tb_sel_ext,
   input wire logic monitor_en,
   input wire logic ext_slow_cfg,
   input wire logic [3:0] dco_divider_ctl,
   input wire logic [7:0] dco_stage_ctl,
   input wire logic monitor_irq,
   input wire logic irq
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);

   a_rdata_idle_zero: assert property (
      !$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not zero outside read slot");
   // Reset itself is the cause here, so it must not disable the check
   a_reset_internal: assert property (disable iff (1'b0)
      reset |=> !osc_sel_ext && int_clock_en && !ext_clock_en)
      else $error("reset did not select internal clock");
   a_int_kept_on: assert property (
      !osc_sel_ext |-> int_clock_en)
      else $error("internal clock off while selected");
   a_mon_enable_gate: assert property (
      $rose(monitor_en) |-> $past(int_clock_en) && $past(ext_clock_en))
      else $error("monitor enabled with a clock off");
   a_mon_stays_on: assert property (
      $fell(monitor_en) |-> $past(reg_wr)
         && $past(reg_addr) == csm_pkg::OFF_CTRL
         && !$past(reg_wdata[csm_pkg::BIT_MON_ON]))
      else $error("monitor dropped without a write");
   a_irq_needs_mon: assert property (
      $rose(monitor_irq) |-> $past(monitor_en))
      else $error("monitor interrupt without monitor on");
   a_int_fail_switch: assert property (
      (monitor_en && int_off_raw && !ext_off_raw) [*7]
         |-> osc_sel_ext && tb_sel_ext)
      else $error("failed internal clock still selected");
   a_ext_fail_switch: assert property (
      (monitor_en && ext_off_raw && !int_off_raw) [*7]
         |-> !osc_sel_ext && !tb_sel_ext)
      else $error("failed external clock still selected");
   a_tb_follows_on: assert property (
      !monitor_en && !$past(monitor_en) |-> tb_sel_ext == ext_clock_en)
      else $error("timebase select not following external on");
   a_stage_cause: assert property (
      $changed(dco_stage_ctl) |-> $past(lf_inc, 2) != $past(lf_dec, 2))
      else $error("stage moved without a single request");
   a_stage_step: assert property (
      $changed(dco_stage_ctl)
         |-> 8'(dco_stage_ctl - $past(dco_stage_ctl)) inside {8'h01, 8'hff})
      else $error("stage moved by more than one step");
endmodule

// ===== verification/testbench.sv
// Purpose: Self-checking bench for the clock source control block
// Assumes: Stable indications held high unless a scenario drops them
// Notes: Reads queue their expectation, a watcher compares read data
`timescale 1ns/1ns
module testbench;
   logic core_clk, reset, reg_wr, reg_rd, int_stable_raw, ext_stable_raw;
   logic int_off_raw, ext_off_raw, lf_inc, lf_dec, rd_seen, up, dn;
   logic [2:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, dco_stage_ctl;
   logic int_clock_en, ext_clock_en, osc_sel_ext, tb_sel_ext, monitor_en;
   logic ext_slow_cfg, monitor_irq, irq;
   logic [3:0] dco_divider_ctl;
   logic [11:0] m;
   logic [31:0] r;
   logic [7:0] exp_q[$];
   logic [7:0] rst_v[7] = '{8'h0c, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00};
   logic [7:0] tw[10] = '{8'h2c, 8'h13, 8'h13, 8'h13, 8'h03, 8'h0b, 8'h0b,
                          8'h8f, 8'haf, 8'haf};
   logic [7:0] te[10] = '{8'h0c, 8'h0f, 8'h1f, 8'h13, 8'h13, 8'h1f, 8'h0f,
                          8'h0f, 8'h2f, 8'haf};
   int n_fail, n_tests, k;

   csm_ctrl DUT (.*);

   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic end_of_test();
      $display("Compares %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Both strobes drop here; wr and rd drop only the other one, so back-to-back calls keep theirs high
   task automatic idle(input int n);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      repeat (n) @(posedge core_clk);
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_rd <= 1'b0;
      reg_wr <= 1'b1;
      @(posedge core_clk);
   endtask

   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      reg_addr <= a;
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      exp_q.push_back(e);
      @(posedge core_clk);
   endtask

   // Read data stand only in the cycle after the strobe
   always @(posedge core_clk) begin
      rd_seen <= reg_rd;
      if (rd_seen === 1'b1)
         chk(reg_rdata, exp_q.pop_front());
   end

   initial begin
      repeat (20000) @(posedge core_clk);
      n_fail++;
      end_of_test();
   end

   initial begin
      void'($urandom(15));
      reset = 1'b1;
      {int_off_raw, ext_off_raw, lf_inc, lf_dec} = 4'h0;
      {int_stable_raw, ext_stable_raw} = 2'b11;
      {reg_addr, reg_wdata} = 11'h000;
      n_fail = 0;
      n_tests = 0;
      idle(2);
      reset <= 1'b0;
      // Synchronisers need a few edges before stable bits show
      idle(6);
      for (int i = 0; i < 7; i++)
         rd(3'(i), rst_v[i]);
      wr(csm_pkg::OFF_CFG, 8'h01);
      wr(3'h6, 8'hff);
      rd(csm_pkg::OFF_CFG, 8'h01);
      rd(3'h6, 8'h00);
      chk(ext_slow_cfg, 1'b1);
      for (int i = 0; i < 10; i++) begin
         wr(csm_pkg::OFF_CTRL, tw[i]);
         idle(6);
         rd(csm_pkg::OFF_CTRL, te[i]);
         chk({monitor_en, osc_sel_ext, int_clock_en, ext_clock_en},
             {te[i][5], te[i][4], te[i][3], te[i][1]});
      end
      ext_stable_raw <= 1'b0;
      idle(6);
      rd(csm_pkg::OFF_CTRL, 8'hae);
      ext_stable_raw <= 1'b1;
      wr(csm_pkg::OFF_IRQ_MASK, 8'h01);
      idle(6);
      int_off_raw <= 1'b1;
      for (k = 0; k < 20 && monitor_irq !== 1'b1; k++)
         @(posedge core_clk);
      if (k == 20) begin
         n_fail++;
         end_of_test();
      end
      idle(2);
      chk({osc_sel_ext, tb_sel_ext, irq}, 3'b111);
      int_off_raw <= 1'b0;
      idle(6);
      // A clearing write without a prior read must leave the flag
      wr(csm_pkg::OFF_CTRL, 8'hbf);
      rd(csm_pkg::OFF_CTRL, 8'hff);
      wr(csm_pkg::OFF_CTRL, 8'hff);
      rd(csm_pkg::OFF_CTRL, 8'hff);
      wr(csm_pkg::OFF_CTRL, 8'hbf);
      rd(csm_pkg::OFF_CTRL, 8'hbf);
      chk({monitor_irq, irq}, 2'b01);
      wr(csm_pkg::OFF_IRQ_STAT, 8'h01);
      idle(1);
      chk(irq, 1'b0);
      rd(csm_pkg::OFF_IRQ_STAT, 8'h02);
      wr(csm_pkg::OFF_CTRL, 8'h1f);
      rd(csm_pkg::OFF_CTRL, 8'h1f);
      // Re-arm the monitor, then lose the external source
      wr(csm_pkg::OFF_CTRL, 8'h3f);
      ext_off_raw <= 1'b1;
      idle(8);
      chk({osc_sel_ext, tb_sel_ext, irq}, 3'b001);
      rd(csm_pkg::OFF_CTRL, 8'h6e);
      m = {csm_pkg::RST_DCO_DIV, csm_pkg::RST_DCO_STAGE};
      // Early run of steps up crosses the stage wrap into the divider
      for (int i = 0; i < 300; i++) begin
         r = $urandom;
         up = i < 140 || r[0];
         dn = i >= 140 && r[1];
         lf_inc <= up;
         lf_dec <= dn;
         idle(1);
         lf_inc <= 1'b0;
         lf_dec <= 1'b0;
         if (up && !dn && m != 12'h9ff)
            m = m + 12'h001;
         else if (dn && !up && m != 12'h000)
            m = m - 12'h001;
         idle(2);
         chk({dco_divider_ctl, dco_stage_ctl}, m);
      end
      wr(csm_pkg::OFF_DCO_STAGE, 8'h00);
      rd(csm_pkg::OFF_DCO_STAGE, m[7:0]);
      rd(csm_pkg::OFF_DCO_DIV, {4'h0, m[11:8]});
      idle(2);
      chk(12'(exp_q.size()), 12'h000);
      end_of_test();
   end
endmodule

bind csm_ctrl csm_ctrl_chk chk (.*);
